//--- design/clock_startup_pkg.sv
// Constants, types and decode functions for clock source and startup sequencing.
// Assumes fuse values are static on-chip levels in the i_clk domain.
// Operation
// - Decode four-bit source select fuse field
// - Fuse one is unprogrammed, zero programmed
// - Default: calibrated RC, divide by eight
// - Hold internal reset after other resets release
// - Timeout counted in watchdog oscillator cycles
// - Timeout lengths: 0, 512 or 8192
// - Ripple count oscillator cycles before release
// - Startup count from 6 to 32K cycles
// - Reset: timeout plus startup; wake from power down or power save: startup only
// - Halted core clock stops core state
// - External interrupt detected while peripherals halted
// - Flash clock gated with core clock
// - Async timer domain runs in idle, noise reduction, power save and extended standby
// - Converter domain runs in noise reduction
// - Sleep modes halt unused domains independently
package clock_startup_pkg;

	// ==========================================================
	// Fuse encoding
	localparam logic FUSE_PROGRAMMED = 1'b0;
	localparam logic [3:0] SEL_EXTERNAL = 4'h0;
	localparam logic [3:0] SEL_RESERVED = 4'h1;
	localparam logic [3:0] SEL_RC_CALIBRATED = 4'h2;
	localparam logic [3:0] SEL_RC_128K = 4'h3;
	localparam logic [3:0] SEL_LF_XTAL_LOW = 4'h4;
	localparam logic [3:0] SEL_FS_XTAL_LOW = 4'h6;
	localparam logic [3:0] SEL_LP_XTAL_LOW = 4'h8;

	// Shipped defaults, 8.0 MHz RC divided to 1.0 MHz
	localparam logic [3:0] DEFAULT_SOURCE_SELECT = 4'h2;
	localparam logic [1:0] DEFAULT_STARTUP_TIME = 2'h2;
	localparam logic DEFAULT_DIVIDE_BY_EIGHT = 1'b0;
	localparam int RC_CALIBRATED_KHZ = 8000;
	localparam int DEFAULT_SYSTEM_KHZ = 1000;

	// ==========================================================
	// Cycle counts
	localparam int TIMEOUT_NONE = 0;
	localparam int TIMEOUT_SHORT = 512;
	localparam int TIMEOUT_LONG = 8192;
	localparam int STARTUP_EXT = 6;
	localparam int STARTUP_258 = 258;
	localparam int STARTUP_1K = 1024;
	localparam int STARTUP_16K = 16384;
	localparam int STARTUP_32K = 32768;
	localparam int CNT_W = 16;
	localparam logic [2:0] DIV8_LAST = 3'h7;

	// ==========================================================
	// Types
	typedef enum logic [2:0]
	{
		KIND_EXTERNAL = 3'b000,
		KIND_RC_CALIBRATED = 3'b001,
		KIND_RC_128K = 3'b010,
		KIND_LF_XTAL = 3'b011,
		KIND_FS_XTAL = 3'b100,
		KIND_LP_XTAL = 3'b101,
		KIND_RESERVED = 3'b110
	} source_kind_e;

	typedef enum logic [1:0]
	{
		TO_NONE = 2'b00,
		TO_SHORT = 2'b01,
		TO_LONG = 2'b10
	} timeout_code_e;

	typedef enum logic [2:0]
	{
		SU_EXT = 3'b000,
		SU_258 = 3'b001,
		SU_1K = 3'b010,
		SU_16K = 3'b011,
		SU_32K = 3'b100
	} startup_code_e;

	typedef enum logic [2:0]
	{
		SLEEP_IDLE = 3'b000,
		SLEEP_NOISE_REDUCTION = 3'b001,
		SLEEP_POWER_DOWN = 3'b010,
		SLEEP_POWER_SAVE = 3'b011,
		SLEEP_STANDBY = 3'b110,
		SLEEP_EXT_STANDBY = 3'b111
	} sleep_mode_e;

	typedef enum logic [2:0]
	{
		ST_HOLD = 3'b000,
		ST_TIMEOUT = 3'b001,
		ST_STARTUP = 3'b010,
		ST_RUN = 3'b011,
		ST_SLEEP = 3'b100,
		ST_WAKE = 3'b101
	} seq_state_e;

	// Domain enables: {core, peripheral, flash, async timer, converter}
	typedef logic [4:0] domain_mask_t;
	localparam domain_mask_t DOMAINS_ALL = 5'h1f;
	localparam domain_mask_t DOMAINS_NONE = 5'h00;

	// ==========================================================
	// Functions
	function automatic source_kind_e decode_source(input logic [3:0] sel);
		source_kind_e k;
		k = KIND_RESERVED;
		if (sel >= SEL_LP_XTAL_LOW)
			k = KIND_LP_XTAL;
		else if (sel >= SEL_FS_XTAL_LOW)
			k = KIND_FS_XTAL;
		else if (sel >= SEL_LF_XTAL_LOW)
			k = KIND_LF_XTAL;
		else if (sel == SEL_RC_128K)
			k = KIND_RC_128K;
		else if (sel == SEL_RC_CALIBRATED)
			k = KIND_RC_CALIBRATED;
		else if (sel == SEL_EXTERNAL)
			k = KIND_EXTERNAL;
		return k;
	endfunction

	function automatic timeout_code_e timeout_select(input source_kind_e k,
		input logic sel0, input logic [1:0] startup_time_fuses);
		timeout_code_e t;
		t = TO_LONG;
		if (k == KIND_LP_XTAL || k == KIND_FS_XTAL)
		begin
			case ({sel0, startup_time_fuses})
				3'h0, 3'h3, 3'h6: t = TO_SHORT;
				3'h2, 3'h5: t = TO_NONE;
				default: t = TO_LONG;
			endcase
		end
		else
		begin
			case (startup_time_fuses)
				2'h0: t = TO_NONE;
				2'h1: t = TO_SHORT;
				default: t = TO_LONG;
			endcase
		end
		return t;
	endfunction

	function automatic startup_code_e startup_select(input source_kind_e k,
		input logic sel0, input logic [1:0] startup_time_fuses);
		startup_code_e s;
		s = SU_EXT;
		if (k == KIND_LP_XTAL || k == KIND_FS_XTAL)
		begin
			if (sel0)
				s = SU_16K;
			else if (startup_time_fuses[1])
				s = SU_1K;
			else
				s = SU_258;
		end
		else if (k == KIND_LF_XTAL)
			s = SU_32K;
		return s;
	endfunction

	function automatic domain_mask_t sleep_domains(input sleep_mode_e m);
		domain_mask_t d;
		case (m)
			SLEEP_IDLE: d = 5'h0b;
			SLEEP_NOISE_REDUCTION: d = 5'h03;
			SLEEP_POWER_SAVE: d = 5'h02;
			SLEEP_EXT_STANDBY: d = 5'h02;
			default: d = DOMAINS_NONE;
		endcase
		return d;
	endfunction

endpackage

//--- design/pin_sync.sv
// Two-stage synchroniser with rising-edge pulse.
// Assumes the input is asynchronous to i_clk.
`timescale 1ns/1ps
module pin_sync
(
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_clk_en,
	input wire logic i_pin,
	input wire logic i_reset_level,
	output logic o_level,
	output logic o_rise
);

	typedef struct packed
	{
		logic meta;
		logic level;
		logic prev;
		logic rise;
	} sync_s;

	sync_s s_r;
	sync_s s_nxt;

	always_comb
	begin
		s_nxt = s_r;
		s_nxt.meta = i_pin;
		s_nxt.level = s_r.meta;
		s_nxt.prev = s_r.level;
		s_nxt.rise = s_r.level & ~s_r.prev;
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			s_r.meta <= 1'b0;
			s_r.level <= 1'b0;
			s_r.prev <= 1'b0;
			s_r.rise <= 1'b0;
		end
		else if (i_clk_en)
			s_r <= s_nxt;
	end

	assign o_level = s_r.level ^ i_reset_level;
	assign o_rise = s_r.rise;

endmodule

//--- design/clock_source_startup_control.sv
// Clock source decode, startup reset sequencing and clock domain gating.
// Assumes oscillator cycles arrive as pin levels toggling once per cycle,
// slow against i_clk, and that sleep and wake requests come from i_clk logic.
`timescale 1ns/1ps
module clock_source_startup_control
#(
	parameter int TIMEOUT_LONG_CYCLES = clock_startup_pkg::TIMEOUT_LONG,
	parameter int STARTUP_16K_CYCLES = clock_startup_pkg::STARTUP_16K,
	parameter int STARTUP_32K_CYCLES = clock_startup_pkg::STARTUP_32K
)
(
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_clk_en,
	input wire logic i_other_reset_n,
	input wire logic i_watchdog_osc,
	input wire logic i_selected_osc,
	input wire logic i_ext_irq_pin,
	input wire logic i_ext_irq_clear,
	input wire logic [3:0] i_clock_source_select_fuses,
	input wire logic [1:0] i_startup_time_fuses,
	input wire logic i_divide_by_eight_fuse,
	input wire logic i_sleep_req,
	input wire clock_startup_pkg::sleep_mode_e i_sleep_mode,
	input wire logic i_wake,
	output logic o_internal_reset,
	output logic o_invalid_source,
	output clock_startup_pkg::source_kind_e o_source_kind,
	output logic o_system_tick,
	output logic o_core_clock_domain_en,
	output logic o_peripheral_clock_domain_en,
	output logic o_flash_clock_domain_en,
	output logic o_async_timer_clock_domain_en,
	output logic o_converter_clock_domain_en,
	output logic o_ext_irq_pending
);
	import clock_startup_pkg::*;

	typedef struct packed
	{
		seq_state_e state;
		logic [CNT_W-1:0] cnt;
		startup_code_e startup;
		sleep_mode_e mode;
		logic [2:0] div_cnt;
		logic system_tick;
		logic internal_reset;
		logic invalid;
		source_kind_e kind;
		domain_mask_t domains;
		logic irq_pending;
	} ctrl_s;

	ctrl_s c_r;
	ctrl_s c_nxt;

	logic other_released;
	logic wdt_tick;
	logic osc_tick;
	logic irq_edge;
	source_kind_e kind_now;
	timeout_code_e to_now;
	startup_code_e su_now;

	// ==========================================================
	// Pin synchronisers
	pin_sync u_other_reset
	(
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_clk_en(i_clk_en),
		.i_pin(i_other_reset_n),
		.i_reset_level(1'b0),
		.o_level(other_released),
		.o_rise()
	);

	pin_sync u_watchdog_osc
	(
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_clk_en(i_clk_en),
		.i_pin(i_watchdog_osc),
		.i_reset_level(1'b0),
		.o_level(),
		.o_rise(wdt_tick)
	);

	pin_sync u_selected_osc
	(
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_clk_en(i_clk_en),
		.i_pin(i_selected_osc),
		.i_reset_level(1'b0),
		.o_level(),
		.o_rise(osc_tick)
	);

	// Runs on i_clk regardless of peripheral gating
	pin_sync u_ext_irq
	(
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_clk_en(i_clk_en),
		.i_pin(i_ext_irq_pin),
		.i_reset_level(1'b0),
		.o_level(),
		.o_rise(irq_edge)
	);

	// ==========================================================
	// Fuse decode
	always_comb
	begin
		kind_now = decode_source(i_clock_source_select_fuses);
		to_now = timeout_select(kind_now, i_clock_source_select_fuses[0],
			i_startup_time_fuses);
		su_now = startup_select(kind_now, i_clock_source_select_fuses[0],
			i_startup_time_fuses);
	end

	function automatic logic [CNT_W-1:0] startup_cycles(input startup_code_e s);
		logic [CNT_W-1:0] n;
		case (s)
			SU_258: n = CNT_W'(STARTUP_258);
			SU_1K: n = CNT_W'(STARTUP_1K);
			SU_16K: n = CNT_W'(STARTUP_16K_CYCLES);
			SU_32K: n = CNT_W'(STARTUP_32K_CYCLES);
			default: n = CNT_W'(STARTUP_EXT);
		endcase
		return n;
	endfunction

	// ==========================================================
	// Sequencer
	always_comb
	begin
		c_nxt = c_r;
		c_nxt.system_tick = 1'b0;

		case (c_r.state)
			ST_HOLD:
			begin
				c_nxt.internal_reset = 1'b1;
				c_nxt.domains = DOMAINS_NONE;
				c_nxt.kind = kind_now;
				c_nxt.invalid = (kind_now == KIND_RESERVED);
				c_nxt.startup = su_now;
				if (other_released && kind_now != KIND_RESERVED)
				begin
					case (to_now)
						TO_SHORT:
						begin
							c_nxt.state = ST_TIMEOUT;
							c_nxt.cnt = CNT_W'(TIMEOUT_SHORT);
						end
						TO_LONG:
						begin
							c_nxt.state = ST_TIMEOUT;
							c_nxt.cnt = CNT_W'(TIMEOUT_LONG_CYCLES);
						end
						default:
						begin
							c_nxt.state = ST_STARTUP;
							c_nxt.cnt = startup_cycles(su_now);
						end
					endcase
				end
			end
			ST_TIMEOUT:
			begin
				if (wdt_tick)
				begin
					if (c_r.cnt <= CNT_W'(1))
					begin
						c_nxt.state = ST_STARTUP;
						c_nxt.cnt = startup_cycles(c_r.startup);
					end
					else
						c_nxt.cnt = c_r.cnt - CNT_W'(1);
				end
			end
			ST_STARTUP, ST_WAKE:
			begin
				if (osc_tick)
				begin
					if (c_r.cnt <= CNT_W'(1))
					begin
						c_nxt.state = ST_RUN;
						c_nxt.internal_reset = 1'b0;
						c_nxt.domains = DOMAINS_ALL;
						c_nxt.div_cnt = 3'h0;
					end
					else
						c_nxt.cnt = c_r.cnt - CNT_W'(1);
				end
			end
			ST_RUN:
			begin
				if (osc_tick && other_released)
				begin
					// Programmed fuse divides the source by eight
					if (i_divide_by_eight_fuse != FUSE_PROGRAMMED)
						c_nxt.system_tick = 1'b1;
					else
					begin
						c_nxt.div_cnt = c_r.div_cnt + 3'h1;
						c_nxt.system_tick = (c_r.div_cnt == DIV8_LAST);
					end
				end
				if (i_sleep_req)
				begin
					c_nxt.state = ST_SLEEP;
					c_nxt.mode = i_sleep_mode;
					c_nxt.domains = sleep_domains(i_sleep_mode);
				end
			end
			ST_SLEEP:
			begin
				if (i_wake)
				begin
					if (c_r.mode == SLEEP_POWER_DOWN || c_r.mode == SLEEP_POWER_SAVE)
					begin
						c_nxt.state = ST_WAKE;
						c_nxt.cnt = startup_cycles(c_r.startup);
					end
					else
					begin
						c_nxt.state = ST_RUN;
						c_nxt.domains = DOMAINS_ALL;
					end
				end
			end
			default:
				c_nxt.state = ST_HOLD;
		endcase

		// Another reset source returning restarts the whole sequence
		if (!other_released)
		begin
			c_nxt.state = ST_HOLD;
			c_nxt.internal_reset = 1'b1;
			c_nxt.domains = DOMAINS_NONE;
		end

		// Edge set wins over a clear in the same cycle
		if (irq_edge)
			c_nxt.irq_pending = 1'b1;
		else if (i_ext_irq_clear)
			c_nxt.irq_pending = 1'b0;
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			c_r.state <= ST_HOLD;
			c_r.cnt <= '0;
			c_r.startup <= SU_EXT;
			c_r.mode <= SLEEP_IDLE;
			c_r.div_cnt <= 3'h0;
			c_r.system_tick <= 1'b0;
			c_r.internal_reset <= 1'b1;
			c_r.invalid <= 1'b0;
			c_r.kind <= KIND_RC_CALIBRATED;
			c_r.domains <= DOMAINS_NONE;
			c_r.irq_pending <= 1'b0;
		end
		else if (i_clk_en)
			c_r <= c_nxt;
	end

	// ==========================================================
	// Outputs
	assign o_internal_reset = c_r.internal_reset;
	assign o_invalid_source = c_r.invalid;
	assign o_source_kind = c_r.kind;
	assign o_system_tick = c_r.system_tick;
	assign o_core_clock_domain_en = c_r.domains[4];
	assign o_peripheral_clock_domain_en = c_r.domains[3];
	assign o_flash_clock_domain_en = c_r.domains[2];
	assign o_async_timer_clock_domain_en = c_r.domains[1];
	assign o_converter_clock_domain_en = c_r.domains[0];
	assign o_ext_irq_pending = c_r.irq_pending;

endmodule

//--- dv/osc_model.sv
// Free-running watchdog and selected oscillator stand-ins.
// Assumes both run slow against the 10 MHz system clock.
`timescale 1ns/1ps
module osc_model
#(
	parameter int WDT_HALF_NS = 400,
	parameter int SEL_HALF_NS = 300
)
(
	output logic o_wdt_osc,
	output logic o_sel_osc
);
	initial
	begin
		o_wdt_osc = 1'b0;
		#133;
		forever #(WDT_HALF_NS) o_wdt_osc = ~o_wdt_osc;
	end
	initial
	begin
		o_sel_osc = 1'b0;
		#17;
		forever #(SEL_HALF_NS) o_sel_osc = ~o_sel_osc;
	end
endmodule

//--- dv/clock_startup_props.sv
// Port checker for the clock source and startup controller.
// Assumes it is bound to clock_source_startup_control.
`timescale 1ns/1ps
module clock_startup_props
import clock_startup_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_other_reset_n,
	input wire logic i_ext_irq_pin,
	input wire logic i_ext_irq_clear,
	input wire logic [3:0] i_clock_source_select_fuses,
	input wire logic i_sleep_req,
	input wire clock_startup_pkg::sleep_mode_e i_sleep_mode,
	input wire logic o_internal_reset,
	input wire logic o_invalid_source,
	input wire logic o_system_tick,
	input wire logic o_core_clock_domain_en,
	input wire logic o_peripheral_clock_domain_en,
	input wire logic o_flash_clock_domain_en,
	input wire logic o_async_timer_clock_domain_en,
	input wire logic o_converter_clock_domain_en,
	input wire logic o_ext_irq_pending
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	logic [4:0] en_w;
	assign en_w = {o_core_clock_domain_en, o_peripheral_clock_domain_en,
		o_flash_clock_domain_en, o_async_timer_clock_domain_en, o_converter_clock_domain_en};
	sequence s_sleep(sleep_mode_e m);
		i_sleep_req && o_core_clock_domain_en && i_sleep_mode == m;
	endsequence
	sequence s_irq_edge;
		$rose(i_ext_irq_pin) ##1 (!i_ext_irq_clear) [*5];
	endsequence

	a_reset_all_off: assert property (o_internal_reset |-> en_w == 5'h00)
		else $error("domain enabled during internal reset");
	a_flash_with_core: assert property (o_flash_clock_domain_en == o_core_clock_domain_en)
		else $error("flash domain apart from core domain");
	a_reserved_flagged: assert property (i_clock_source_select_fuses == 4'h1 |=> o_invalid_source)
		else $error("reserved source not flagged");
	a_reserved_held: assert property (o_invalid_source |-> o_internal_reset)
		else $error("reset released on reserved source");
	a_nr_conv_runs: assert property (s_sleep(SLEEP_NOISE_REDUCTION) |-> ##[1:2] en_w == 5'h03)
		else $error("noise reduction domains wrong");
	a_psave_async_runs: assert property (s_sleep(SLEEP_POWER_SAVE) |-> ##[1:2] en_w == 5'h02)
		else $error("power save domains wrong");
	a_tick_in_run: assert property (o_system_tick |-> !o_internal_reset)
		else $error("tick during internal reset");
	a_irq_caught: assert property (s_irq_edge |-> o_ext_irq_pending)
		else $error("interrupt edge lost");
	a_other_reset_hold: assert property ((!i_other_reset_n) [*5] |-> o_internal_reset)
		else $error("internal reset low with other reset active");
endmodule

bind clock_source_startup_control clock_startup_props i_props (.*);

//--- dv/tb_top.sv
// Self-checking bench for the clock source and startup controller.
// Assumes osc_model supplies both oscillators.
`timescale 1ns/1ps
module tb_top;
	import clock_startup_pkg::*;
	localparam int WP = 8;
	localparam int SP = 6;
	logic i_clk, i_reset_n, i_clk_en, i_other_reset_n, i_ext_irq_pin, i_ext_irq_clear;
	logic i_divide_by_eight_fuse, i_sleep_req, i_wake, wdt_osc, sel_osc;
	logic [3:0] i_clock_source_select_fuses;
	logic [1:0] i_startup_time_fuses;
	sleep_mode_e i_sleep_mode;
	logic o_internal_reset, o_invalid_source, o_system_tick, o_ext_irq_pending;
	source_kind_e o_source_kind;
	logic [4:0] en;
	int num_errors, cmp_count;

	osc_model i_osc (.o_wdt_osc(wdt_osc), .o_sel_osc(sel_osc));
	clock_source_startup_control #(.TIMEOUT_LONG_CYCLES(16), .STARTUP_16K_CYCLES(20),
		.STARTUP_32K_CYCLES(24)) i_dut (.i_clk(i_clk), .i_reset_n(i_reset_n),
		.i_clk_en(i_clk_en), .i_other_reset_n(i_other_reset_n), .i_watchdog_osc(wdt_osc),
		.i_selected_osc(sel_osc), .i_ext_irq_pin(i_ext_irq_pin),
		.i_ext_irq_clear(i_ext_irq_clear),
		.i_clock_source_select_fuses(i_clock_source_select_fuses),
		.i_startup_time_fuses(i_startup_time_fuses),
		.i_divide_by_eight_fuse(i_divide_by_eight_fuse), .i_sleep_req(i_sleep_req),
		.i_sleep_mode(i_sleep_mode), .i_wake(i_wake), .o_internal_reset(o_internal_reset),
		.o_invalid_source(o_invalid_source), .o_source_kind(o_source_kind),
		.o_system_tick(o_system_tick), .o_core_clock_domain_en(en[4]),
		.o_peripheral_clock_domain_en(en[3]), .o_flash_clock_domain_en(en[2]),
		.o_async_timer_clock_domain_en(en[1]), .o_converter_clock_domain_en(en[0]),
		.o_ext_irq_pending(o_ext_irq_pending));

	initial
	begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end

	task automatic cycles(input int n);
		repeat (n) @(posedge i_clk);
	endtask

	task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check_range(input int got, input int lo, input int hi);
		cmp_count++;
		if (got < lo || got > hi)
		begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h to %h", $time, got, lo, hi);
		end
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic t_decode();
		source_kind_e k;
		i_other_reset_n <= 1'b0;
		for (int s = 0; s < 16; s++)
		begin
			i_clock_source_select_fuses <= 4'(s);
			cycles(3);
			k = s >= 8 ? KIND_LP_XTAL : s >= 6 ? KIND_FS_XTAL : s >= 4 ? KIND_LF_XTAL :
				s == 3 ? KIND_RC_128K : s == 2 ? KIND_RC_CALIBRATED :
				s == 1 ? KIND_RESERVED : KIND_EXTERNAL;
			check_val(o_source_kind, k);
			check_val(o_invalid_source, s == 1);
		end
		i_clock_source_select_fuses <= 4'h1;
		cycles(3);
		i_other_reset_n <= 1'b1;
		cycles(600);
		check_val({o_internal_reset, o_invalid_source}, 2'h3);
		$display("decode test done");
	endtask

	task automatic t_startup(input logic [3:0] sel, input logic [1:0] startup_time_fuses, input logic div,
		input int n, input int m);
		int cyc;
		int ticks;
		i_other_reset_n <= 1'b0;
		i_clock_source_select_fuses <= sel;
		i_startup_time_fuses <= startup_time_fuses;
		i_divide_by_eight_fuse <= div;
		cycles(8);
		i_other_reset_n <= 1'b1;
		cyc = 0;
		@(posedge i_clk);
		while (o_internal_reset === 1'b1 && cyc < 20000)
		begin
			@(posedge i_clk);
			cyc++;
		end
		check_range(cyc, (n > 0 ? n - 1 : 0) * WP + (m - 2) * SP, n * WP + m * SP + 10);
		cycles(1);
		check_val(en, 5'h1f);
		ticks = 0;
		repeat (48 * SP)
		begin
			@(posedge i_clk);
			ticks += (o_system_tick === 1'b1);
		end
		check_range(ticks, div ? 47 : 5, div ? 49 : 7);
		$display("startup test done for source %h", sel);
	endtask

	task automatic t_sleep(input sleep_mode_e m, input logic [4:0] exp);
		int cyc;
		logic deep;
		deep = (m == SLEEP_POWER_DOWN || m == SLEEP_POWER_SAVE);
		i_sleep_mode <= m;
		i_sleep_req <= 1'b1;
		@(posedge i_clk);
		i_sleep_req <= 1'b0;
		cycles(3);
		check_val(en, exp);
		i_ext_irq_pin <= 1'b1;
		cycles(8);
		check_val(o_ext_irq_pending, 1'b1);
		i_ext_irq_pin <= 1'b0;
		i_ext_irq_clear <= 1'b1;
		i_wake <= 1'b1;
		@(posedge i_clk);
		i_wake <= 1'b0;
		i_ext_irq_clear <= 1'b0;
		cyc = 0;
		while (en[4] !== 1'b1 && cyc < 400)
		begin
			@(posedge i_clk);
			cyc++;
		end
		check_val(o_internal_reset, 1'b0);
		check_range(cyc, deep ? 4 * SP : 0, deep ? 6 * SP + 8 : 2);
		check_val(o_ext_irq_pending, 1'b0);
		$display("sleep test done for mode %h", m);
	endtask

	initial
	begin
		i_reset_n = 1'b0;
		i_clk_en = 1'b1;
		i_other_reset_n = 1'b0;
		i_ext_irq_pin = 1'b0;
		i_ext_irq_clear = 1'b0;
		i_divide_by_eight_fuse = 1'b0;
		i_sleep_req = 1'b0;
		i_wake = 1'b0;
		i_clock_source_select_fuses = 4'h2;
		i_startup_time_fuses = 2'h2;
		i_sleep_mode = SLEEP_IDLE;
		cycles(6);
		i_reset_n <= 1'b1;
		cycles(2);
		t_decode();
		t_startup(4'h0, 2'h0, 1'b1, 0, 6);
		t_startup(4'h3, 2'h1, 1'b1, 512, 6);
		t_startup(4'h4, 2'h2, 1'b1, 16, 24);
		t_startup(4'hf, 2'h2, 1'b1, 512, 20);
		t_startup(4'h6, 2'h2, 1'b1, 0, 1024);
		t_startup(4'h8, 2'h0, 1'b1, 512, 258);
		t_startup(DEFAULT_SOURCE_SELECT, DEFAULT_STARTUP_TIME,
			DEFAULT_DIVIDE_BY_EIGHT, 16, 6);
		t_sleep(SLEEP_IDLE, 5'h0b);
		t_sleep(SLEEP_NOISE_REDUCTION, 5'h03);
		t_sleep(SLEEP_POWER_DOWN, 5'h00);
		t_sleep(SLEEP_POWER_SAVE, 5'h02);
		t_sleep(SLEEP_STANDBY, 5'h00);
		t_sleep(SLEEP_EXT_STANDBY, 5'h02);
		tally_and_finish();
	end

	initial
	begin
		cycles(80000);
		num_errors++;
		$display("watchdog expired");
		tally_and_finish();
	end
endmodule
